// ==== src/insn_decode_pkg.sv ====
/*
 Shared constants for the instruction field decoder: word layout,
 class and operation encodings, phase count of an instruction cycle.
 Assumes nothing of its surroundings.
*/
package insn_decode_pkg;
   localparam int WORD_W = 14;
   localparam int FADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int LIT8_W = 8;
   localparam int LIT11_W = 11;
   // field positions
   localparam int CLASS_HI = 13;
   localparam int CLASS_LO = 12;
   localparam int OP4_HI = 11;
   localparam int OP4_LO = 8;
   localparam int DEST_POS = 7;
   localparam int FADDR_HI = 6;
   localparam int BIT_HI = 9;
   localparam int BIT_LO = 7;
   localparam int JUMP_POS = 11;
   // class codes in bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;
   // byte opcodes in bits 11:8
   localparam logic [3:0] BOP_MISC = 4'h0;
   localparam logic [3:0] BOP_DECFSZ = 4'hB;
   localparam logic [3:0] BOP_INCFSZ = 4'hF;
   // bit opcodes in bits 11:10
   localparam logic [1:0] BITOP_TEST_CLR = 2'h2;
   localparam logic [1:0] BITOP_TEST_SET = 2'h3;
   // literal opcodes: bits 11:10 value for return-with-literal
   localparam logic [1:0] LOP_RET_LIT = 2'h1;
   // full words with fixed encodings
   localparam logic [WORD_W-1:0] W_RETURN = 14'h0008;
   localparam logic [WORD_W-1:0] W_RETINT = 14'h0009;
   localparam logic [WORD_W-1:0] W_NOP = 14'h0000;
   localparam logic [6:0] NOP_LOW_MASK = 7'h1F;
   // one instruction cycle is four oscillator periods
   localparam int PHASES = 4;
   localparam logic [1:0] PHASE_LAST = 2'(PHASES - 1);

   typedef enum logic [1:0]
   {
      CLASS_BYTE = 2'b00,
      CLASS_BIT = 2'b01,
      CLASS_LIT = 2'b10
   } insn_class_t;

   typedef enum logic [0:0]
   {
      SEQ_EXEC = 1'b0,
      SEQ_FLUSH = 1'b1
   } seq_state_t;
endpackage : insn_decode_pkg

// ==== src/insn_field_decoder.sv ====
/*
 Instruction field decoder and cycle sequencer for a small 8-bit core.
 Assumes the fetch path holds insn_word stable while fetch_valid is high
 and samples it once per instruction cycle; cond_true comes from the
 datapath during execution of a skip instruction, valid by the end of the last phase.
*/
`timescale 1ns/100ps
module insn_field_decoder
   import insn_decode_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WORD_W-1:0] insn_word,
   input wire logic fetch_valid,
   input wire logic cond_true,
   output logic [1:0] phase,
   output logic cycle_start,
   output logic insn_strobe,
   output insn_class_t insn_class,
   output logic dest_file,
   output logic [FADDR_W-1:0] file_addr,
   output logic [BIT_W-1:0] bit_sel,
   output logic [LIT11_W-1:0] literal,
   output logic literal_long,
   output logic two_cycle,
   output logic flush_nop,
   output logic [WORD_W-1:0] op_word
);
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   seq_state_t seq_reg;
   seq_state_t seq_next;
   logic cycle_start_reg;
   logic insn_strobe_reg;
   insn_class_t class_reg;
   logic dest_reg;
   logic [FADDR_W-1:0] faddr_reg;
   logic [BIT_W-1:0] bit_reg;
   logic [LIT11_W-1:0] lit_reg;
   logic lit_long_reg;
   logic two_cycle_reg;
   logic flush_reg;
   logic [WORD_W-1:0] op_word_reg;
   logic skip_pending_reg;

   // field split of the incoming word
   wire [1:0] cls_bits = insn_word[CLASS_HI:CLASS_LO];
   wire [3:0] op4 = insn_word[OP4_HI:OP4_LO];
   wire [1:0] bitop = insn_word[OP4_HI:OP4_HI-1];
   wire last_phase = (phase_reg == PHASE_LAST);
   // word after a branch, or the word skipped by a true test, is refused
   wire flush_now = (seq_reg == SEQ_FLUSH) || (skip_pending_reg && cond_true);
   wire take = last_phase && !flush_now && fetch_valid;

   // class: top bits 00 byte, 01 bit, 1x literal/control
   wire is_byte = (cls_bits == CLS_BYTE);
   wire is_bit = (cls_bits == CLS_BIT);
   wire is_jump = (cls_bits == CLS_JUMP);
   wire is_lit = (cls_bits == CLS_LIT);
   wire insn_class_t class_dec = is_byte ? CLASS_BYTE
                               : is_bit ? CLASS_BIT : CLASS_LIT;

   // control words: fixed encodings in the byte class, return-with-literal in the literal class
   wire is_return = (insn_word == W_RETURN);
   wire is_retint = (insn_word == W_RETINT);
   wire is_ret_lit = is_lit && (bitop == LOP_RET_LIT);
   wire is_ctl_word = is_byte && (op4 == BOP_MISC) && !insn_word[DEST_POS];

   // fixed program counter change: jumps and returns
   wire pc_change = is_jump || is_return || is_retint || is_ret_lit;
   // conditional skips: test result arrives from the datapath
   wire is_skip = (is_byte && ((op4 == BOP_DECFSZ) || (op4 == BOP_INCFSZ)))
                  || (is_bit && ((bitop == BITOP_TEST_CLR) || (bitop == BITOP_TEST_SET)));

   // destination meaningful only in byte class; control words force W
   wire dest_dec = is_byte && !is_ctl_word && insn_word[DEST_POS];
   wire [FADDR_W-1:0] faddr_dec = insn_word[FADDR_HI:0];
   wire [BIT_W-1:0] bit_dec = is_bit ? insn_word[BIT_HI:BIT_LO] : '0;
   // 11-bit target for jumps, 8-bit constant otherwise; upper bits zero
   wire lit_long_dec = is_jump;
   wire [LIT11_W-1:0] lit_dec = lit_long_dec ? insn_word[LIT11_W-1:0]
                                : {{(LIT11_W-LIT8_W){1'b0}}, insn_word[LIT8_W-1:0]};
   // don't-care bits ignored: normalise nop-class word to all zero
   wire nop_form = is_ctl_word
                   && ((insn_word[FADDR_HI:0] & NOP_LOW_MASK) == W_NOP[FADDR_HI:0]);
   wire [WORD_W-1:0] op_dec = nop_form ? W_NOP : insn_word;

   // next field values: decoded on a take, no-operation otherwise
   wire insn_class_t class_next = take ? class_dec : CLASS_BYTE;
   wire dest_next = take && dest_dec;
   wire two_cycle_next = take && pc_change;
   wire skip_next = take && is_skip;
   wire [FADDR_W-1:0] faddr_next = take ? faddr_dec : '0;
   wire [BIT_W-1:0] bit_next = take ? bit_dec : '0;
   wire [LIT11_W-1:0] lit_next = take ? lit_dec : '0;
   wire lit_long_next = take && lit_long_dec;
   wire [WORD_W-1:0] op_word_next = take ? op_dec : W_NOP;

   // phase counter: four oscillator periods per instruction cycle
   assign phase_next = last_phase ? 2'h0 : phase_reg + 2'h1;

   // second cycle of a branch or a true skip executes as no-operation
   always_comb
   begin
      seq_next = seq_reg;
      if (last_phase)
      begin
         unique case (seq_reg)
            SEQ_EXEC:
               seq_next = (take && pc_change) ? SEQ_FLUSH : SEQ_EXEC;
            SEQ_FLUSH:
               seq_next = SEQ_EXEC;
         endcase
      end
   end

   // sequencer: phase counter and flush state
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         phase_reg <= 2'h0;
         seq_reg <= SEQ_EXEC;
      end
      else
      begin
         phase_reg <= phase_next;
         seq_reg <= seq_next;
      end
   end

   // one-cycle pulses in phase 0
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         cycle_start_reg <= 1'b0;
         insn_strobe_reg <= 1'b0;
      end
      else
      begin
         cycle_start_reg <= last_phase;
         insn_strobe_reg <= take;
      end
   end

   // flush marks the whole cycle that runs as no-operation
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         flush_reg <= 1'b0;
      else if (last_phase)
         flush_reg <= flush_now;
   end

   // class group, loaded once per instruction cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         class_reg <= CLASS_BYTE;
         dest_reg <= 1'b0;
         two_cycle_reg <= 1'b0;
         skip_pending_reg <= 1'b0;
      end
      else if (last_phase)
      begin
         class_reg <= class_next;
         dest_reg <= dest_next;
         two_cycle_reg <= two_cycle_next;
         skip_pending_reg <= skip_next;
      end
   end

   // operand fields, loaded together with the class
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         faddr_reg <= '0;
         bit_reg <= '0;
         lit_reg <= '0;
         lit_long_reg <= 1'b0;
      end
      else if (last_phase)
      begin
         faddr_reg <= faddr_next;
         bit_reg <= bit_next;
         lit_reg <= lit_next;
         lit_long_reg <= lit_long_next;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         op_word_reg <= W_NOP;
      else if (last_phase)
         op_word_reg <= op_word_next;
   end

   assign phase = phase_reg;
   assign cycle_start = cycle_start_reg;
   assign insn_strobe = insn_strobe_reg;
   assign insn_class = class_reg;
   assign dest_file = dest_reg;
   assign file_addr = faddr_reg;
   assign bit_sel = bit_reg;
   assign literal = lit_reg;
   assign literal_long = lit_long_reg;
   assign two_cycle = two_cycle_reg;
   assign flush_nop = flush_reg;
   assign op_word = op_word_reg;
endmodule : insn_field_decoder

// ==== verification/insn_field_decoder_props.sv ====
/*
 Port checker for the instruction field decoder.
 Assumes one clock, ref_clk, and async active-high reset.
*/
`timescale 1ns/100ps
module insn_field_decoder_props
   import insn_decode_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic fetch_valid,
   input wire logic [1:0] phase,
   input wire logic cycle_start,
   input wire logic insn_strobe,
   input wire insn_class_t insn_class,
   input wire logic dest_file,
   input wire logic [FADDR_W-1:0] file_addr,
   input wire logic [BIT_W-1:0] bit_sel,
   input wire logic [LIT11_W-1:0] literal,
   input wire logic literal_long,
   input wire logic two_cycle,
   input wire logic flush_nop
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_phase_wrap: assert property (phase == 2'h3 |=> phase == 2'h0)
      else $error("phase did not wrap to 0");
   chk_phase_step: assert property (phase != 2'h3 |=> phase == $past(phase) + 2'h1)
      else $error("phase did not step by one");
   chk_start_phase: assert property (cycle_start |-> phase == 2'h0)
      else $error("cycle start outside phase 0");
   chk_strobe_take: assert property (insn_strobe |-> $past(fetch_valid) && $past(phase) == 2'h3)
      else $error("strobe without a take");
   chk_fields_hold: assert property (phase != 2'h0 |-> $stable(literal) && $stable(file_addr) && $stable(insn_class))
      else $error("fields changed mid cycle");
   chk_flush_after: assert property (insn_strobe && two_cycle |-> ##4 (flush_nop && !insn_strobe))
      else $error("no flush after two-cycle word");
   chk_dest_class: assert property (dest_file |-> insn_class == CLASS_BYTE)
      else $error("dest set outside byte class");
   chk_bitsel_class: assert property (insn_class != CLASS_BIT |-> bit_sel == 3'h0)
      else $error("bit select outside bit class");
   chk_long_lit: assert property (literal_long |-> insn_class == CLASS_LIT && two_cycle)
      else $error("long literal on wrong word");
   chk_short_lit: assert property (!literal_long |-> literal[10:8] == 3'h0)
      else $error("short literal not zero-extended");
   chk_flush_quiet: assert property (flush_nop |-> !insn_strobe && !two_cycle && !dest_file)
      else $error("flush cycle not a no-operation");
   cover property (insn_strobe && dest_file);
   cover property (insn_strobe && insn_class == CLASS_BIT);
   cover property (insn_strobe && literal_long);
   cover property (flush_nop && phase == 2'h3);
endmodule : insn_field_decoder_props

bind insn_field_decoder insn_field_decoder_props insn_field_decoder_props_inst (.ref_clk,
   .reset, .fetch_valid, .phase, .cycle_start, .insn_strobe, .insn_class, .dest_file,
   .file_addr, .bit_sel, .literal, .literal_long, .two_cycle, .flush_nop);

// ==== verification/fetch_model.sv ====
/*
 Fetch path model that presents program words to the decoder.
 Assumes the bench changes word_in and fetch_valid off the rising edge.
*/
`timescale 1ns/100ps
module fetch_model
   import insn_decode_pkg::*;
(
   input wire logic [WORD_W-1:0] word_in,
   input wire logic fetch_valid,
   output logic [WORD_W-1:0] insn_word
);
   // idle bus shows a changed pattern, not the last word
   assign insn_word = fetch_valid ? word_in : ~word_in;
endmodule : fetch_model

// ==== verification/tb.sv ====
/*
 Self-checking bench for the instruction field decoder.
 Assumes the fetch model above and a 40 MHz ref_clk.
*/
`timescale 1ns/100ps
module tb;
   import insn_decode_pkg::*;
   logic ref_clk, reset, fetch_valid, cond_true, cycle_start, insn_strobe, dest_file;
   logic literal_long, two_cycle, flush_nop, pend_two, pend_skip;
   logic [1:0] phase;
   logic [13:0] word_next, insn_word, op_word;
   logic [6:0] file_addr;
   logic [2:0] bit_sel;
   logic [10:0] literal;
   logic [31:0] r;
   insn_class_t insn_class;
   int n_fail = 0;
   int samples_checked = 0;
   int seed = 32'h7100;
   fetch_model fetch_model_inst (.word_in(word_next), .fetch_valid(fetch_valid),
      .insn_word(insn_word));
   insn_field_decoder insn_field_decoder_inst (.ref_clk(ref_clk), .reset(reset),
      .insn_word(insn_word), .fetch_valid(fetch_valid), .cond_true(cond_true), .phase(phase),
      .cycle_start(cycle_start), .insn_strobe(insn_strobe), .insn_class(insn_class),
      .dest_file(dest_file), .file_addr(file_addr), .bit_sel(bit_sel), .literal(literal),
      .literal_long(literal_long), .two_cycle(two_cycle), .flush_nop(flush_nop),
      .op_word(op_word));
   initial
   begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic run(input logic [13:0] w, input logic c, input logic v);
      logic flush, take, lng, two;
      logic [1:0] cl;
      flush = pend_two | (pend_skip & c);
      take = v & ~flush;
      cl = w[13] ? 2'h2 : {1'b0, w[12]};
      lng = w[13:12] == 2'h2;
      two = lng | w == 14'h0008 | w == 14'h0009 | w[13:10] == 4'hD;
      while (phase !== 2'h3)
         @(negedge ref_clk);
      word_next = w;
      cond_true = c;
      fetch_valid = v;
      @(negedge ref_clk);
      check("strobe", {13'h0, take}, {13'h0, insn_strobe});
      check("flush", {13'h0, flush}, {13'h0, flush_nop});
      check("start", 14'h1, {13'h0, cycle_start});
      check("phase", 14'h0, {12'h0, phase});
      if (take)
      begin
         check("class", {12'h0, cl}, {12'h0, insn_class});
         check("dest", {13'h0, cl == 2'h0 && w[7]}, {13'h0, dest_file});
         if (!cl[1])
            check("addr", {7'h0, w[6:0]}, {7'h0, file_addr});
         check("bit", {11'h0, cl == 2'h1 ? w[9:7] : 3'h0}, {11'h0, bit_sel});
         check("lit", {3'h0, lng ? w[10:0] : {3'h0, w[7:0]}}, {3'h0, literal});
         check("two", {13'h0, two}, {13'h0, two_cycle});
         check("word", (w & 14'h3F9F) == 14'h0 ? 14'h0 : w, op_word);
      end
      else
      begin
         check("idle word", 14'h0, op_word);
         check("idle two", 14'h0, {13'h0, two_cycle});
         check("idle long", 14'h0, {13'h0, literal_long});
      end
      pend_two = take & two;
      pend_skip = take & ((cl == 2'h0 && (w[11:8] == 4'hB || w[11:8] == 4'hF)) ||
         (cl == 2'h1 && w[11]));
   endtask : run
   initial
   begin
      reset = 1;
      fetch_valid = 0;
      cond_true = 0;
      word_next = 14'h0;
      pend_two = 0;
      pend_skip = 0;
      repeat (20) @(negedge ref_clk);
      reset = 0;
      // nop with don't-cares set, goto, skip taken, return, control word
      run(14'h0060, 0, 1);
      run(14'h2ABC, 0, 1);
      run(14'h3FFF, 0, 1);
      run(14'h0B85, 0, 1);
      run(14'h1F7F, 1, 1);
      run(14'h1D03, 0, 1);
      run(14'h0088, 0, 1);
      run(14'h3456, 1, 1);
      run(14'h0008, 0, 1);
      run(14'h0008, 0, 1);
      run(14'h0009, 0, 1);
      run(14'h0009, 0, 1);
      run(14'h0111, 0, 0);
      run(14'h0111, 0, 0);
      $display("corner test done");
      repeat (300)
      begin
         r = $random(seed);
         run(r[13:0], r[14], r[16:15] != 2'h0);
      end
      $display("random test done");
      reset = 1;
      repeat (2) @(negedge ref_clk);
      check("reset phase", 14'h0, {12'h0, phase});
      check("reset strobe", 14'h0, {13'h0, insn_strobe});
      check("reset flush", 14'h0, {13'h0, flush_nop});
      check("reset word", 14'h0, op_word);
      reset = 0;
      pend_two = 0;
      pend_skip = 0;
      run(14'h1385, 0, 1);
      $display("reset test done");
      print_verdict();
   end
   initial
   begin
      #(25 * 8 * 2000);
      n_fail++;
      print_verdict();
   end
endmodule : tb
